// File: rtl/pxp_core.sv
// Purpose: serial-bus target core of a 16-bit port expander with change alert
// Assumes: bus and pins are sampled by the 250 MHz clock, which far outruns the bus clock
// Notes:   open-drain pins give a zero value and an active-low enable
//
// Function
// - reset returns every register and the bus state machine to defaults.
// - an edge on an input-configured pin raises the alert while its port differs from the last read value.
// - alert becomes valid only after a fixed settling delay.
// - pending alert clears on data return, port read, or stop.
// - read clearing happens at the acknowledge bit, on the clock falling edge.
// - after clearing, each further input change is detected again.
// - traffic to other bus targets changes alert state only through its stop, which clears it.
// - output pins never alert; output-to-input switch may raise a false one.
// - clearing is tracked per port; one port read keeps the other pending.
// - alert is active low and open drain.
// - registers form four pairs; successive bytes alternate within a pair.
// - any number of data bytes per write, alternation continuing.
// - read is command write, repeated start, address with direction 1.
// - repeated start keeps the currently accessed register as pointer.
// - further read bytes alternate between the two registers of a pair.
// - pin levels captured into input register at acknowledge rising edge.
// - stop may end a transfer anytime; last acknowledged data stands.
// - target address is 0100 followed by the three strap bits.
// - command low three bits select one of eight registers.
// - a set polarity bit inverts the reported input value.
// - configuration 1 makes a pin a released input, 0 a driven output.
`timescale 1ns/1ps
`default_nettype none
module pxp_core
    import pxp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       addr_strap_bit0_i,
    input  wire logic       addr_strap_bit1_i,
    input  wire logic       addr_strap_bit2_i,
    input  wire logic [7:0] port_zero_pins_i,
    input  wire logic [7:0] port_one_pins_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_n_o,
    output var  logic       alert_o,
    output var  logic       alert_oe_n_o,
    output var  logic [7:0] port_zero_pins_o,
    output var  logic [7:0] port_zero_pins_oe_n_o,
    output var  logic [7:0] port_one_pins_o,
    output var  logic [7:0] port_one_pins_oe_n_o
);
    function automatic logic [7:0] port_byte(input logic [15:0] v, input logic sel);
        return sel ? v[15:8] : v[7:0];
    endfunction

    // input synchroniser; third stage only feeds edge detection
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s3_q;

    assign raw = {scl_i, sda_i, addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i,
                  port_one_pins_i, port_zero_pins_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic        scl;
    logic        sda;
    logic        scl_rise;
    logic        scl_fall;
    logic        start;
    logic        stop;
    logic [2:0]  strap;
    logic [15:0] live;
    logic [15:0] pin_edge;

    assign scl      = s2_q[SYNC_SCL];
    assign sda      = s2_q[SYNC_SDA];
    assign scl_rise = scl & ~s3_q[SYNC_SCL];
    assign scl_fall = ~scl & s3_q[SYNC_SCL];
    assign start    = scl & s3_q[SYNC_SCL] & s3_q[SYNC_SDA] & ~sda;
    assign stop     = scl & s3_q[SYNC_SCL] & ~s3_q[SYNC_SDA] & sda;
    assign strap    = s2_q[SYNC_STRAP_LSB +: 3];
    assign live     = s2_q[PORT_W-1:0];
    assign pin_edge = s2_q[PORT_W-1:0] ^ s3_q[PORT_W-1:0];

    // register file
    logic        wr_en;
    logic [2:0]  nxt_ptr;
    logic [7:0]  rd_data;
    logic [63:0] regs;
    logic [15:0] out_v;
    logic [15:0] pol_v;
    logic [15:0] cfg_v;
    logic [2:0]  ptr_q;
    logic [7:0]  sh_q;

    pxp_regfile u_regfile (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (ptr_q),
        .wr_data_i (sh_q),
        .rd_addr_i (nxt_ptr),
        .rd_data_o (rd_data),
        .regs_o    (regs)
    );

    assign out_v = regs[8*REG_OUT0 +: 16];
    assign pol_v = regs[8*REG_POL0 +: 16];
    assign cfg_v = regs[8*REG_CFG0 +: 16];

    // bus state machine
    pxp_state_t  state_q;
    pxp_state_t  state_d;
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;
    logic [7:0]  sh_d;
    logic [2:0]  ptr_d;
    logic        mack_q;
    logic        mack_d;
    logic        sda_oe_n_q;
    logic        sda_oe_n_d;
    logic [15:0] snap_q;
    logic [15:0] snap_d;
    logic [2:0]  snap_init_q;
    logic [1:0]  rd_clr;
    logic [7:0]  tx;
    logic        addr_hit;

    assign addr_hit = (sh_q[7:1] == {ADDR_PREFIX, strap});
    // the upcoming byte belongs to the partner register while in read acknowledge
    assign nxt_ptr  = (state_q == ST_RD_ACK) ? {ptr_q[2:1], ~ptr_q[0]} : ptr_q;
    assign tx       = (nxt_ptr[2:1] == PAIR_IN) ? port_byte(snap_q ^ pol_v, nxt_ptr[0]) : rd_data;

    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        sh_d       = sh_q;
        ptr_d      = ptr_q;
        mack_d     = mack_q;
        sda_oe_n_d = sda_oe_n_q;
        snap_d     = snap_q;
        wr_en      = 1'b0;
        rd_clr     = 2'b00;
        // sync stages hold their reset ones for two cycles, so wait for real pin levels
        if (!snap_init_q[2]) begin
            snap_d = live;
        end
        if (stop) begin
            // committed bytes stay; a partial byte is dropped
            state_d    = ST_IDLE;
            sda_oe_n_d = 1'b1;
        end else if (start) begin
            // pointer left alone, so a restart reads the register in progress
            state_d    = ST_ADDR;
            cnt_d      = 4'h0;
            sda_oe_n_d = 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_ADDR, ST_CMD, ST_WR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda};
                        cnt_d = cnt_q + BIT_FIRST;
                    end else if (scl_fall && cnt_q == BIT_LAST) begin
                        sda_oe_n_d = 1'b0;
                        if (state_q == ST_ADDR) begin
                            if (addr_hit) begin
                                state_d = ST_ADDR_ACK;
                            end else begin
                                state_d    = ST_IDLE;
                                sda_oe_n_d = 1'b1;
                            end
                        end else if (state_q == ST_CMD) begin
                            ptr_d   = sh_q[2:0];
                            state_d = ST_CMD_ACK;
                        end else begin
                            wr_en   = 1'b1;
                            state_d = ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_rise && sh_q[0] && nxt_ptr[2:1] == PAIR_IN) begin
                        snap_d[8*nxt_ptr[0] +: 8] = port_byte(live, nxt_ptr[0]);
                    end
                    if (scl_fall) begin
                        if (sh_q[0]) begin
                            sh_d       = {tx[6:0], 1'b0};
                            sda_oe_n_d = tx[7];
                            cnt_d      = BIT_FIRST;
                            state_d    = ST_RD;
                        end else begin
                            sda_oe_n_d = 1'b1;
                            cnt_d      = 4'h0;
                            state_d    = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        if (state_q == ST_WR_ACK) begin
                            ptr_d = {ptr_q[2:1], ~ptr_q[0]};
                        end
                        sda_oe_n_d = 1'b1;
                        cnt_d      = 4'h0;
                        state_d    = ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_q == BIT_LAST) begin
                            sda_oe_n_d = 1'b1;
                            state_d    = ST_RD_ACK;
                        end else begin
                            sda_oe_n_d = sh_q[7];
                            sh_d       = {sh_q[6:0], 1'b0};
                            cnt_d      = cnt_q + BIT_FIRST;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        mack_d = ~sda;
                        // a refused byte is never sent, so the partner port keeps its snapshot and alert
                        if (nxt_ptr[2:1] == PAIR_IN && !sda) begin
                            snap_d[8*nxt_ptr[0] +: 8] = port_byte(live, nxt_ptr[0]);
                        end
                    end
                    if (scl_fall) begin
                        if (ptr_q[2:1] == PAIR_IN) begin
                            rd_clr[ptr_q[0]] = 1'b1;
                        end
                        ptr_d = nxt_ptr;
                        if (mack_q) begin
                            sh_d       = {tx[6:0], 1'b0};
                            sda_oe_n_d = tx[7];
                            cnt_d      = BIT_FIRST;
                            state_d    = ST_RD;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d    = ST_IDLE;
                    sda_oe_n_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= ST_IDLE;
            cnt_q       <= 4'h0;
            sh_q        <= 8'h00;
            ptr_q       <= REG_IN0;
            mack_q      <= 1'b0;
            sda_oe_n_q  <= 1'b1;
            snap_q      <= 16'h0000;
            snap_init_q <= 3'h0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            sh_q        <= sh_d;
            ptr_q       <= ptr_d;
            mack_q      <= mack_d;
            sda_oe_n_q  <= sda_oe_n_d;
            snap_q      <= snap_d;
            snap_init_q <= {snap_init_q[1:0], 1'b1};
        end
    end

    // change detection, per port
    logic [1:0]             mism;
    logic [1:0]             mism_prev_q;
    logic [1:0]             pend_set;
    logic [1:0]             pend_q;
    logic [1:0]             pend_d;
    logic [ALERT_CNT_W-1:0] dly_q;
    logic [ALERT_CNT_W-1:0] dly_d;
    logic                   alert_oe_n_q;
    logic                   alert_oe_n_d;

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            // only input pins compare, so outputs never alert
            assign mism[gp] = |((live[8*gp +: 8] ^ snap_q[8*gp +: 8]) & cfg_v[8*gp +: 8]);
            // a fresh mismatch also covers a pin turned from output to input
            // no alert until the snapshot holds real pins, else reset ones look like edges
            assign pend_set[gp] = snap_init_q[2] & mism[gp]
                                & ((|(pin_edge[8*gp +: 8] & cfg_v[8*gp +: 8])) | ~mism_prev_q[gp]);
            // set wins over every clear source
            assign pend_d[gp] = pend_set[gp] | (pend_q[gp] & mism[gp] & ~rd_clr[gp] & ~stop);
        end
    endgenerate

    always_comb begin
        dly_d = {ALERT_CNT_W{1'b0}};
        if (|pend_q) begin
            dly_d = (dly_q == ALERT_VALID_CYC) ? dly_q : dly_q + 12'h001;
        end
        alert_oe_n_d = ~((|pend_q) && dly_q == ALERT_VALID_CYC);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mism_prev_q  <= 2'b11;
            pend_q       <= 2'b00;
            dly_q        <= {ALERT_CNT_W{1'b0}};
            alert_oe_n_q <= 1'b1;
        end else begin
            mism_prev_q  <= mism;
            pend_q       <= pend_d;
            dly_q        <= dly_d;
            alert_oe_n_q <= alert_oe_n_d;
        end
    end

    // pin drivers
    logic [15:0] pin_q;
    logic [15:0] pin_oe_n_q;
    logic        low_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q      <= {OUT_RST, OUT_RST};
            pin_oe_n_q <= {CFG_RST, CFG_RST};
            low_q      <= 1'b0;
        end else begin
            pin_q      <= out_v;
            pin_oe_n_q <= cfg_v;
            low_q      <= 1'b0;
        end
    end

    assign sda_o                 = low_q;
    assign sda_oe_n_o            = sda_oe_n_q;
    assign alert_o               = low_q;
    assign alert_oe_n_o          = alert_oe_n_q;
    assign port_zero_pins_o      = pin_q[7:0];
    assign port_zero_pins_oe_n_o = pin_oe_n_q[7:0];
    assign port_one_pins_o       = pin_q[15:8];
    assign port_one_pins_oe_n_o  = pin_oe_n_q[15:8];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_cmd_end;
        state_q == ST_CMD && scl_fall && cnt_q == BIT_LAST && !start && !stop;
    endsequence

    sequence s_ack_low;
        !sda_oe_n_q && state_q == ST_CMD_ACK;
    endsequence

    a_reset_idle: assert property ($past(rst_i) |-> state_q == ST_IDLE && sda_oe_n_q && pend_q == 2'b00)
        else $error("state not at default after reset");
    a_edge_sets: assert property ((snap_init_q[2] && mism[1] && |(pin_edge[15:8] & cfg_v[15:8])) |=> pend_q[1])
        else $error("input edge did not set pending");
    a_alert_delay: assert property ($fell(alert_oe_n_q) |-> $past(dly_q) == ALERT_VALID_CYC && |$past(pend_q))
        else $error("alert asserted before settling delay");
    a_stop_clears: assert property ((stop && pend_set == 2'b00) |=> pend_q == 2'b00)
        else $error("stop did not clear pending");
    a_clear_at_ack: assert property (rd_clr != 2'b00 |-> state_q == ST_RD_ACK && scl_fall)
        else $error("read clear outside acknowledge fall");
    a_port_isolate: assert property ((rd_clr == 2'b01 && pend_q[1] && mism[1] && !stop) |=> pend_q[1])
        else $error("port zero read cleared port one");
    a_output_quiet: assert property ((cfg_v[7:0] == 8'h00) |=> !pend_q[0])
        else $error("output pins raised pending");
    a_cmd_ack: assert property (s_cmd_end |=> s_ack_low ##0 ptr_q == 3'($past(sh_q)))
        else $error("command byte not acknowledged or latched");
    a_pair_toggle: assert property ((state_q == ST_WR_ACK && scl_fall && !start && !stop)
        |=> ptr_q == ($past(ptr_q) ^ 3'h1))
        else $error("write pointer did not alternate");
    a_addr_miss: assert property ((state_q == ST_ADDR && scl_fall && cnt_q == BIT_LAST && !addr_hit && !start && !stop)
        |=> state_q == ST_IDLE && sda_oe_n_q [*2])
        else $error("foreign address not ignored");
    a_restart_ptr: assert property (start |=> $stable(ptr_q) && state_q == ST_ADDR)
        else $error("restart changed pointer");
endmodule
`default_nettype wire

// File: rtl/pxp_pkg.sv
// Purpose: shared constants and types of the port expander target core
// Assumes: one 250 MHz system clock
// Notes:   register indices are the command byte low bits
package pxp_pkg;
    localparam int unsigned CLK_FREQ_MHZ         = 250;
    localparam int unsigned ALERT_VALID_DELAY_NS = 4000;
    localparam int unsigned ALERT_VALID_CYC_INT  = (ALERT_VALID_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned ALERT_CNT_W          = 12;
    localparam logic [ALERT_CNT_W-1:0] ALERT_VALID_CYC = ALERT_VALID_CYC_INT[ALERT_CNT_W-1:0];

    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned NUM_REGS  = 8;
    localparam int unsigned PORT_W    = 16;
    localparam int unsigned SYNC_W    = 21;
    localparam int unsigned SYNC_SCL  = 20;
    localparam int unsigned SYNC_SDA  = 19;
    localparam int unsigned SYNC_STRAP_LSB = 16;

    localparam logic [3:0] ADDR_PREFIX = 4'h4;
    localparam logic [3:0] BIT_LAST    = 4'h8;
    localparam logic [3:0] BIT_FIRST   = 4'h1;

    localparam logic [2:0] REG_IN0  = 3'h0;
    localparam logic [2:0] REG_IN1  = 3'h1;
    localparam logic [2:0] REG_OUT0 = 3'h2;
    localparam logic [2:0] REG_OUT1 = 3'h3;
    localparam logic [2:0] REG_POL0 = 3'h4;
    localparam logic [2:0] REG_POL1 = 3'h5;
    localparam logic [2:0] REG_CFG0 = 3'h6;
    localparam logic [2:0] REG_CFG1 = 3'h7;
    localparam logic [1:0] PAIR_IN  = 2'h0;
    localparam logic [1:0] PAIR_OUT = 2'h1;
    localparam logic [1:0] PAIR_POL = 2'h2;
    localparam logic [1:0] PAIR_CFG = 2'h3;

    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hff;
    localparam logic [SYNC_W-1:0] SYNC_RST = 21'h1fffff;

    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_CMD      = 9'h008,
        ST_CMD_ACK  = 9'h010,
        ST_WR       = 9'h020,
        ST_WR_ACK   = 9'h040,
        ST_RD       = 9'h080,
        ST_RD_ACK   = 9'h100
    } pxp_state_t;

    function automatic logic [7:0] pxp_reg_rst(input logic [2:0] idx);
        logic [1:0] pair;
        pair = idx[2:1];
        if (pair == PAIR_OUT) begin
            return OUT_RST;
        end else if (pair == PAIR_POL) begin
            return POL_RST;
        end else if (pair == PAIR_CFG) begin
            return CFG_RST;
        end
        return 8'h00;
    endfunction
endpackage

// File: rtl/pxp_regfile.sv
// Purpose: writable register pairs of the expander with a registered read port
// Assumes: writes to the input pair are dropped, those registers live in the core
// Notes:   all registers are also exposed flat for the pin and alert logic
`timescale 1ns/1ps
`default_nettype none
module pxp_regfile
    import pxp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_en_i,
    input  wire logic [2:0]  wr_addr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic [2:0]  rd_addr_i,
    output var  logic [7:0]  rd_data_o,
    output var  logic [63:0] regs_o
);
    logic [7:0] mem_q [NUM_REGS];
    logic [7:0] mem_d [NUM_REGS];
    logic [7:0] rd_d;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            localparam logic [2:0] IDX = 3'(gi);
            always_comb begin
                mem_d[gi] = mem_q[gi];
                if (wr_en_i && wr_addr_i == IDX && IDX[2:1] != PAIR_IN) begin
                    mem_d[gi] = wr_data_i;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mem_q[gi] <= pxp_reg_rst(IDX);
                end else begin
                    mem_q[gi] <= mem_d[gi];
                end
            end
            assign regs_o[8*gi +: 8] = mem_q[gi];
        end
    endgenerate

    always_comb begin
        rd_d = mem_q[rd_addr_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= rd_d;
        end
    end
endmodule
`default_nettype wire

// File: dv/pxp_master.sv
// Purpose: bus master model that drives the clock and data lines of the expander
// Assumes: data line is open drain, resolved with a pull-up in the bench
// Notes:   one phase is eight system clocks, so one bit takes 128 ns
`timescale 1ns/1ps
`default_nettype none
module pxp_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // lines change only on a system clock edge, well away from the other line's edges
    task automatic step(input logic s, input logic d);
        repeat (8) @(posedge clk_i);
        scl_o <= s;
        sda_o <= d;
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start();
        step(scl_o, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic bit_x(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        step(1'b1, b);
        r = sda_i;
        step(1'b0, b);
    endtask
    // msb first; a read passes ff and a low ack_m acks, a high ack_m leaves the byte unacked
    task automatic xfer(input logic [7:0] d, input logic ack_m, output logic [7:0] rd, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            rd[i] = r;
        end
        bit_x(ack_m, ack);
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: self-checking bench for the port expander target core
// Assumes: straps set to 5, so the target answers at 25
// Notes:   alert waits exceed the 1000-cycle settling delay
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pxp_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [2:0] strap = 3'h5;
    logic [7:0] p0    = 8'h12;
    logic [7:0] p1    = 8'h34;
    logic       scl, m_sda, sda_o, sda_oe_n, alr_o, alr_oe_n, sda_w, irq;
    logic [7:0] p0o, p0e, p1o, p1e;
    int         failures  = 0;
    int         cmp_count = 0;
    int         cyc       = 0;
    assign sda_w = m_sda & (sda_oe_n | sda_o);
    assign irq   = alr_oe_n | alr_o;
    always #2 clk_i = ~clk_i;
    pxp_master m_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
    pxp_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
        .addr_strap_bit0_i(strap[0]), .addr_strap_bit1_i(strap[1]), .addr_strap_bit2_i(strap[2]),
        .port_zero_pins_i(p0), .port_one_pins_i(p1), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .alert_o(alr_o), .alert_oe_n_o(alr_oe_n), .port_zero_pins_o(p0o), .port_zero_pins_oe_n_o(p0e),
        .port_one_pins_o(p1o), .port_one_pins_oe_n_o(p1e));
    task automatic close_out();
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic [7:0] r;
        logic       a;
        m_u.xfer(d, 1'b1, r, a);
        chk({7'h0, a}, {7'h0, exp_ack});
    endtask
    task automatic rb(input logic nack, input logic [7:0] exp);
        logic [7:0] r;
        logic       a;
        m_u.xfer(8'hff, nack, r, a);
        chk(r, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic al(input logic e);
        chk({7'h0, irq}, {7'h0, e});
    endtask
    // ceiling is about two and a half times the planned run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        wt(6);
        rst_i <= 1'b0;
        wt(8);
        chk({sda_oe_n, irq, 6'h0}, 8'hc0);
        chk(p0o & p1o & p0e & p1e, 8'hff);
        m_u.start();
        wb(8'h4a, 1'b0);
        wb(8'h03, 1'b0);
        wb(8'ha5, 1'b0);
        wb(8'h5a, 1'b0);
        wb(8'h3c, 1'b0);
        al(1'b1);
        m_u.stop();
        chk(p1o, 8'h3c);
        chk(p0o, 8'h5a);
        m_u.start();
        wb(8'h4a, 1'b0);
        wb(8'hf4, 1'b0);
        wb(8'hf0, 1'b0);
        wb(8'h0f, 1'b0);
        m_u.start();
        wb(8'h4a, 1'b0);
        wb(8'h06, 1'b0);
        wb(8'h00, 1'b0);
        m_u.stop();
        chk(p0e, 8'h00);
        chk(p1e, 8'hff);
        m_u.start();
        wb(8'h4a, 1'b0);
        wb(8'h01, 1'b0);
        m_u.start();
        wb(8'h4b, 1'b0);
        rb(1'b0, 8'h3b);
        m_u.start();
        wb(8'h4b, 1'b0);
        rb(1'b1, 8'he2);
        m_u.stop();
        p1 <= 8'h35;
        wt(900);
        al(1'b1);
        wt(200);
        al(1'b0);
        m_u.start();
        wb(8'h40, 1'b1);
        al(1'b0);
        m_u.start();
        wb(8'h4a, 1'b0);
        wb(8'h00, 1'b0);
        m_u.start();
        wb(8'h4b, 1'b0);
        rb(1'b1, 8'he2);
        wt(12);
        al(1'b0);
        m_u.start();
        wb(8'h4b, 1'b0);
        rb(1'b1, 8'h3a);
        wt(12);
        al(1'b1);
        m_u.stop();
        p1 <= 8'h34;
        wt(1100);
        al(1'b0);
        p1 <= 8'h35;
        wt(12);
        al(1'b1);
        p0 <= 8'hff;
        wt(1100);
        al(1'b1);
        p1 <= 8'h30;
        wt(1100);
        al(1'b0);
        m_u.start();
        wb(8'h4a, 1'b0);
        m_u.stop();
        wt(12);
        al(1'b1);
        rst_i <= 1'b1;
        wt(6);
        rst_i <= 1'b0;
        wt(8);
        chk(p0e, 8'hff);
        close_out();
    end
endmodule
`default_nettype wire
